// *** sltm_monitor.sv ***
// Serial link timeout alarm: monitor, register port and negative response
`timescale 1ns/1ps
module sltm_monitor
  import sltm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SLTM_SEC_CYCLES
) (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [15:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire logic msg_rx, // Pulse: complete host message received
  input wire logic msg_is_write, // Received message is a write request
  output logic nak_valid, // Pulse: send negative response
  output logic [3:0] nak_code, // Exception code of negative response
  output logic ack_valid, // Pulse: message accepted
  output logic comm_loss_alarm, // Communication error alarm level
  output logic op_run, // Controlled operation enabled
  output logic irq // Interrupt level
);
  typedef struct packed {
    logic [1:0] act;
    logic serial;
    logic ro;
    logic [9:0] limit;
    logic [9:0] elapsed;
    logic alarm;
    logic run;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [15:0] rdata;
    logic nak;
    logic ack;
    logic [39:0] quiet; // Silent cycles, read only by the assertions
  } sltm_st_s;
  sltm_st_s st_reg;
  sltm_st_s st_next;

  logic tick;
  logic active;
  logic [2:0] ev;
  logic [9:0] wtime;

  sltm_sec_tick #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(msg_rx),
    .tick(tick)
  );

  assign active = st_reg.serial && (st_reg.act != SLTM_ACT_OFF);
  assign wtime = reg_wdata[9:0];

  always_comb begin
    st_next = st_reg;
    st_next.nak = 1'b0;
    st_next.ack = 1'b0;
    st_next.rdata = SLTM_RESET_DATA;
    ev = 3'b000;
    // Register writes; the read-only range only limits host messages,
    // so local software can still reconfigure the monitor, except the monitoring time while the action is off
    if (reg_wr) begin
      unique case (reg_addr)
        SLTM_OFF_CTRL: begin
          if (reg_wdata[1:0] != 2'b11) begin
            st_next.act = reg_wdata[1:0];
          end
          st_next.serial = reg_wdata[SLTM_CTRL_SERIAL_BIT];
          st_next.ro = reg_wdata[SLTM_CTRL_RO_BIT];
          if (reg_wdata[SLTM_CTRL_RESTART_BIT]) begin
            st_next.run = 1'b1;
          end
        end
        SLTM_OFF_TIME: begin
          if (st_reg.act != SLTM_ACT_OFF && wtime >= SLTM_TIME_MIN &&
              wtime <= SLTM_TIME_MAX) begin
            st_next.limit = wtime;
          end
        end
        SLTM_OFF_IRQ: st_next.irq_stat = st_reg.irq_stat & ~reg_wdata[2:0];
        SLTM_OFF_MASK: st_next.irq_mask = reg_wdata[2:0];
        default: ;
      endcase
    end
    // Read data is registered and stands only in the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        SLTM_OFF_CTRL: st_next.rdata = {11'h000, st_reg.ro, st_reg.serial, 1'b0, st_reg.act};
        SLTM_OFF_TIME: st_next.rdata = (st_reg.act == SLTM_ACT_OFF) ? 16'h0000 :
                                       {6'h00, st_reg.limit};
        SLTM_OFF_STAT: st_next.rdata = {14'h0000, st_reg.run, st_reg.alarm};
        SLTM_OFF_IRQ: st_next.rdata = {13'h0000, st_reg.irq_stat};
        SLTM_OFF_MASK: st_next.rdata = {13'h0000, st_reg.irq_mask};
        default: st_next.rdata = 16'h0000;
      endcase
    end
    // Every message gets exactly one answer, never both
    if (msg_rx) begin
      if (msg_is_write && st_reg.ro) begin
        st_next.nak = 1'b1;
        ev[SLTM_IRQ_NAK_BIT] = 1'b1;
      end else begin
        st_next.ack = 1'b1;
      end
    end
    if (msg_rx || !active) begin
      st_next.elapsed = 10'h000;
    // Saturate rather than wrap, so a long silence never looks short
    end else if (tick && st_reg.elapsed != 10'h3FF) begin
      st_next.elapsed = st_reg.elapsed + 10'h001;
    end
    // Cycle count of the same silence, a cross-check on the seconds timer
    if (msg_rx || !active) begin
      st_next.quiet = 40'h00_0000_0000;
    end else if (st_reg.quiet != 40'hFF_FFFF_FFFF) begin
      st_next.quiet = st_reg.quiet + 40'h00_0000_0001;
    end
    if (!active) begin
      st_next.alarm = 1'b0;
    end else if (msg_rx) begin
      if (st_reg.alarm) begin
        ev[SLTM_IRQ_CLEAR_BIT] = 1'b1;
      end
      st_next.alarm = 1'b0;
    end else if (!st_reg.alarm && st_reg.elapsed > st_reg.limit) begin
      st_next.alarm = 1'b1;
      ev[SLTM_IRQ_RAISE_BIT] = 1'b1;
      if (st_reg.act == SLTM_ACT_STOP) begin
        st_next.run = 1'b0;
      end
    end
    // Set wins over clear-on-write
    st_next.irq_stat = st_next.irq_stat | ev;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.act <= SLTM_ACT_OFF;
      st_reg.limit <= SLTM_TIME_DFLT;
      // Operation allowed from reset; only a stop-action alarm halts it
      st_reg.run <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign nak_valid = st_reg.nak;
  assign nak_code = st_reg.nak ? SLTM_EXC_PROHIBITED : 4'h0;
  assign ack_valid = st_reg.ack;
  assign comm_loss_alarm = st_reg.alarm;
  assign op_run = st_reg.run;
  assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

  // Assertions
  // Monitor gating and alarm
  // off never alarms
  off_no_alarm_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg.act == SLTM_ACT_OFF) |=> !comm_loss_alarm)
    else $error("alarm while action off");
  serial_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_reg.serial |=> !comm_loss_alarm)
    else $error("alarm outside serial mode");
  alarm_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(comm_loss_alarm) |-> $past(st_reg.elapsed) > $past(st_reg.limit))
    else $error("alarm before window exceeded");
  alarm_early_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(comm_loss_alarm) |->
    $past(st_reg.quiet) >= 40'($past(st_reg.limit)) * 40'(SEC_CYCLES))
    else $error("alarm before the window could pass");
  alarm_due_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (active && !msg_rx && !comm_loss_alarm && st_reg.elapsed > st_reg.limit) |=>
    comm_loss_alarm)
    else $error("alarm missing after window");
  auto_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (comm_loss_alarm && msg_rx) |=> !comm_loss_alarm)
    else $error("alarm not cleared by message");
  alarm_holds_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (comm_loss_alarm && active && !msg_rx) |=> comm_loss_alarm)
    else $error("alarm dropped without message");
  inactive_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !active |=> st_reg.elapsed == 10'h000 && !comm_loss_alarm)
    else $error("inactive monitor still counting");

  // Operation control
  // continue keeps running
  run_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg.act == SLTM_ACT_RUN && op_run && !(reg_wr && reg_addr == SLTM_OFF_CTRL))
    |=> op_run)
    else $error("operation stopped in continue mode");
  stop_halts_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ($rose(comm_loss_alarm) && $past(st_reg.act) == SLTM_ACT_STOP) |-> !op_run)
    else $error("stop action did not halt");
  no_self_resume_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(op_run) |-> $past(reg_wr) && $past(reg_wdata[SLTM_CTRL_RESTART_BIT]))
    else $error("operation resumed by itself");
  halt_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!op_run && !(reg_wr && reg_addr == SLTM_OFF_CTRL &&
    reg_wdata[SLTM_CTRL_RESTART_BIT])) |=> !op_run)
    else $error("halt left without restart");
  reset_state_a: assert property (@(posedge mclk)
    $fell(sys_rst) |-> st_reg.act == SLTM_ACT_OFF && !comm_loss_alarm && op_run &&
    st_reg.limit == SLTM_TIME_DFLT)
    else $error("wrong state after reset");
  action_code_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg.act != 2'b11)
    else $error("illegal action code stored");

  // Timer and settings
  // range kept
  limit_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg.limit >= SLTM_TIME_MIN && st_reg.limit <= SLTM_TIME_MAX)
    else $error("monitoring time out of range");
  time_taken_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (reg_wr && reg_addr == SLTM_OFF_TIME && st_reg.act != SLTM_ACT_OFF &&
    wtime >= SLTM_TIME_MIN && wtime <= SLTM_TIME_MAX) |=> st_reg.limit == $past(wtime))
    else $error("valid monitoring time not taken");
  time_refused_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (reg_wr && reg_addr == SLTM_OFF_TIME &&
    (wtime < SLTM_TIME_MIN || wtime > SLTM_TIME_MAX)) |=> $stable(st_reg.limit))
    else $error("out of range time taken");
  time_locked_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg.act == SLTM_ACT_OFF) |=> $stable(st_reg.limit))
    else $error("monitoring time changed while off");
  time_hidden_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (reg_rd && reg_addr == SLTM_OFF_TIME && st_reg.act == SLTM_ACT_OFF) |=>
    reg_rdata == 16'h0000)
    else $error("monitoring time visible while off");
  timer_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
    msg_rx |=> st_reg.elapsed == 10'h000)
    else $error("timer not restarted");
  second_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (active && !msg_rx && !tick) |=> $stable(st_reg.elapsed))
    else $error("timer moved between seconds");
  second_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (active && !msg_rx && tick && st_reg.elapsed != 10'h3FF) |=>
    st_reg.elapsed == $past(st_reg.elapsed) + 10'h001)
    else $error("timer missed a second");

  // Host answers
  // read-only write refused
  ro_nak_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (msg_rx && msg_is_write && st_reg.ro) |=> nak_valid && nak_code == 4'h2 && !ack_valid)
    else $error("missing negative response");
  nak_code_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !nak_valid |-> nak_code == 4'h0)
    else $error("exception code without negative response");
  one_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(nak_valid && ack_valid))
    else $error("both answers at once");
  ack_given_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (msg_rx && !(msg_is_write && st_reg.ro)) |=> ack_valid && !nak_valid)
    else $error("accepted message not acknowledged");
  no_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !msg_rx |=> !nak_valid && !ack_valid)
    else $error("answer without message");

  // Register port and interrupts
  rdata_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  rdata_stat_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (reg_rd && reg_addr == SLTM_OFF_STAT) |=>
    reg_rdata == {14'h0000, $past(op_run), $past(comm_loss_alarm)})
    else $error("status read wrong");
  raise_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(comm_loss_alarm) |-> st_reg.irq_stat[SLTM_IRQ_RAISE_BIT])
    else $error("raise event not flagged");
  clear_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ($fell(comm_loss_alarm) && $past(msg_rx) && $past(active)) |->
    st_reg.irq_stat[SLTM_IRQ_CLEAR_BIT])
    else $error("clear event not flagged");
  nak_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    nak_valid |-> st_reg.irq_stat[SLTM_IRQ_NAK_BIT])
    else $error("negative response not flagged");
  stat_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(reg_wr && reg_addr == SLTM_OFF_IRQ) |=>
    (st_reg.irq_stat & $past(st_reg.irq_stat)) == $past(st_reg.irq_stat))
    else $error("status bit lost without clear");
  irq_masked_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg.irq_mask == 3'b000) |-> !irq)
    else $error("interrupt while all masked");

  cov_raise_c: cover property (@(posedge mclk) $rose(comm_loss_alarm));
  cov_clear_c: cover property (@(posedge mclk) $fell(comm_loss_alarm));
  cov_stop_c: cover property (@(posedge mclk) $fell(op_run));
  cov_nak_c: cover property (@(posedge mclk) nak_valid);
  cov_restart_c: cover property (@(posedge mclk) $rose(op_run));
endmodule // sltm_monitor

// *** sltm_pkg.sv ***
// Package with constants and types for the serial link timeout alarm
package sltm_pkg;
  // Clock rate and one-second tick
  localparam int unsigned SLTM_CLK_HZ = 100_000_000;
  localparam int unsigned SLTM_SEC_S = 1;
  localparam int unsigned SLTM_SEC_CYCLES = SLTM_CLK_HZ * SLTM_SEC_S;
  // Monitoring time range in seconds
  localparam logic [9:0] SLTM_TIME_MIN = 10'h01E;
  localparam logic [9:0] SLTM_TIME_MAX = 10'h258;
  localparam logic [9:0] SLTM_TIME_DFLT = 10'h01E;
  // Register offsets
  localparam logic [3:0] SLTM_OFF_CTRL = 4'h0;
  localparam logic [3:0] SLTM_OFF_TIME = 4'h1;
  localparam logic [3:0] SLTM_OFF_STAT = 4'h2;
  localparam logic [3:0] SLTM_OFF_IRQ = 4'h3;
  localparam logic [3:0] SLTM_OFF_MASK = 4'h4;
  // Control register fields
  localparam int unsigned SLTM_CTRL_ACT_LSB = 0;
  localparam int unsigned SLTM_CTRL_SERIAL_BIT = 2;
  localparam int unsigned SLTM_CTRL_RO_BIT = 3;
  localparam int unsigned SLTM_CTRL_RESTART_BIT = 4;
  // Status fields
  localparam int unsigned SLTM_STAT_ALARM_BIT = 0;
  localparam int unsigned SLTM_STAT_RUN_BIT = 1;
  // Interrupt bits
  localparam int unsigned SLTM_IRQ_RAISE_BIT = 0;
  localparam int unsigned SLTM_IRQ_CLEAR_BIT = 1;
  localparam int unsigned SLTM_IRQ_NAK_BIT = 2;
  // Negative response exception code: setting prohibited
  localparam logic [3:0] SLTM_EXC_PROHIBITED = 4'h2;
  localparam logic [15:0] SLTM_RESET_DATA = 16'h0000;

  typedef enum logic [1:0] {
    SLTM_ACT_OFF = 2'b00,
    SLTM_ACT_RUN = 2'b01,
    SLTM_ACT_STOP = 2'b10
  } sltm_act_e;
endpackage : sltm_pkg

// *** sltm_sec_tick.sv ***
// One-second tick generator for the link monitor
`timescale 1ns/1ps
module sltm_sec_tick
  import sltm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SLTM_SEC_CYCLES
) (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic restart, // Realign tick phase
  output logic tick // One-cycle pulse per second
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } sltm_tick_s;
  sltm_tick_s st_reg;
  sltm_tick_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (restart) begin
      st_next.cnt = 32'h0000_0000;
    end else if (st_reg.cnt >= 32'(SEC_CYCLES - 1)) begin
      st_next.cnt = 32'h0000_0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule // sltm_sec_tick

// *** sltm_host_model.sv ***
// Host model: periodic serial requests toward the link monitor
`timescale 1ns/1ps
module sltm_host_model (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic en, // Send requests while high
  input wire logic wr, // Requests are writes
  output logic msg_rx, // Message complete pulse
  output logic msg_is_write // Write qualifier
);
  logic [7:0] cnt_reg;
  always_ff @(posedge mclk) begin
    cnt_reg <= (sys_rst || !en || msg_rx) ? 8'h00 : cnt_reg + 8'h01;
    msg_rx <= !sys_rst && en && (cnt_reg == 8'h63);
  end
  // Qualifier is noise outside a message, so a design must not trust it
  assign msg_is_write = msg_rx ? wr : cnt_reg[0];
endmodule // sltm_host_model

// *** testbench.sv ***
// Self-checking bench for the serial link timeout alarm
`timescale 1ns/1ps
module testbench;
  import sltm_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic h_en = 1'b0, h_wr = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic msg_rx, msg_is_write, nak_valid, ack_valid, comm_loss_alarm, op_run, irq;
  logic [3:0] nak_code;
  logic [15:0] tv [4] = '{16'h001D, 16'h0259, 16'h0258, 16'h001E};
  logic [15:0] te [4] = '{16'h001E, 16'h001E, 16'h0258, 16'h001E};
  int mismatches = 0;
  int n_checks = 0;
  initial forever #5 mclk = ~mclk;
  // Short second keeps the 30 s window near 300 cycles
  sltm_monitor #(.SEC_CYCLES(10)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .msg_rx(msg_rx), .msg_is_write(msg_is_write),
    .nak_valid(nak_valid), .nak_code(nak_code), .ack_valid(ack_valid),
    .comm_loss_alarm(comm_loss_alarm), .op_run(op_run), .irq(irq));
  sltm_host_model host_u (.mclk(mclk), .sys_rst(sys_rst), .en(h_en), .wr(h_wr),
    .msg_rx(msg_rx), .msg_is_write(msg_is_write));
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    idle(1);
    reg_wr <= 1'b0;
    idle(1);
  endtask
  task rd_chk(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    idle(1);
    chk($sformatf("reg %0h", a), e, reg_rdata);
    reg_rd <= 1'b0;
    idle(1);
  endtask
  // Bounded wait for the alarm level; a miss ends the run
  task wait_alarm(input logic e, input int n);
    for (int i = 0; i < n && comm_loss_alarm !== e; i++) idle(1);
    chk("alarm wait", {15'h0000, e}, {15'h0000, comm_loss_alarm});
    if (comm_loss_alarm !== e) final_report;
  endtask
  // One message; returns just after the edge that takes it
  task send_msg(input logic w);
    h_en <= 1'b1;
    h_wr <= w;
    for (int i = 0; i < 200 && msg_rx !== 1'b1; i++) idle(1);
    chk("msg_rx", 16'h0001, {15'h0000, msg_rx});
    if (msg_rx !== 1'b1) final_report;
    h_en <= 1'b0;
    idle(1);
  endtask
  initial begin
    idle(10);
    sys_rst <= 1'b0;
    idle(1);
    chk("alarm", 16'h0000, {15'h0000, comm_loss_alarm});
    chk("op_run", 16'h0001, {15'h0000, op_run});
    rd_chk(SLTM_OFF_CTRL, 16'h0000);
    wr_reg(SLTM_OFF_TIME, 16'h0064);
    rd_chk(SLTM_OFF_TIME, 16'h0000);
    rd_chk(4'hF, 16'h0000);
    wr_reg(SLTM_OFF_MASK, 16'h0007);
    wr_reg(SLTM_OFF_CTRL, 16'h0001);
    idle(400);
    chk("alarm", 16'h0000, {15'h0000, comm_loss_alarm});
    wr_reg(SLTM_OFF_CTRL, 16'h0004);
    idle(400);
    chk("alarm", 16'h0000, {15'h0000, comm_loss_alarm});
    wr_reg(SLTM_OFF_CTRL, 16'h0005);
    rd_chk(SLTM_OFF_TIME, 16'h001E);
    for (int i = 0; i < 4; i++) begin
      wr_reg(SLTM_OFF_TIME, tv[i]);
      rd_chk(SLTM_OFF_TIME, te[i]);
    end
    send_msg(1'b0);
    chk("ack", 16'h0001, {15'h0000, ack_valid});
    idle(305);
    chk("alarm", 16'h0000, {15'h0000, comm_loss_alarm});
    wait_alarm(1'b1, 20);
    chk("op_run", 16'h0001, {15'h0000, op_run});
    rd_chk(SLTM_OFF_STAT, 16'h0003);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr_reg(SLTM_OFF_MASK, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr_reg(SLTM_OFF_MASK, 16'h0007);
    wr_reg(SLTM_OFF_IRQ, 16'h0001);
    send_msg(1'b0);
    chk("alarm", 16'h0000, {15'h0000, comm_loss_alarm});
    rd_chk(SLTM_OFF_IRQ, 16'h0002);
    wr_reg(SLTM_OFF_IRQ, 16'h0002);
    h_en <= 1'b1;
    idle(600);
    chk("alarm", 16'h0000, {15'h0000, comm_loss_alarm});
    h_en <= 1'b0;
    wr_reg(SLTM_OFF_CTRL, 16'h0006);
    wait_alarm(1'b1, 400);
    chk("op_run", 16'h0000, {15'h0000, op_run});
    send_msg(1'b0);
    chk("alarm", 16'h0000, {15'h0000, comm_loss_alarm});
    chk("op_run", 16'h0000, {15'h0000, op_run});
    wr_reg(SLTM_OFF_CTRL, 16'h0016);
    chk("op_run", 16'h0001, {15'h0000, op_run});
    wr_reg(SLTM_OFF_CTRL, 16'h000E);
    send_msg(1'b1);
    chk("nak", 16'h0001, {15'h0000, nak_valid});
    chk("nak_code", {12'h000, SLTM_EXC_PROHIBITED}, {12'h000, nak_code});
    rd_chk(SLTM_OFF_IRQ, 16'h0007);
    final_report;
  end
endmodule // testbench
